/* File: rtl/spc_pkg.sv */
// Purpose: Shared constants and types for the synthesizer override and calibration control
// Assumes: Registers reached over a simple byte-wide serial-port register access
// Notes: Functional notes below
package spc_pkg;
  localparam logic [7:0] ADDR_OVERRIDE = 8'h58;
  localparam logic [7:0] ADDR_TRIM = 8'h59;
  localparam logic [7:0] ADDR_RESET = 8'h5c;
  localparam logic [7:0] ADDR_CALCTL = 8'h5d;
  localparam logic [7:0] ADDR_CALSTAT = 8'h5e;
  localparam logic [7:0] RST_OVERRIDE = 8'h00;
  localparam logic [6:0] RST_TRIM = 7'h00;
  localparam logic [7:0] RST_RESET = 8'h00;
  localparam logic [7:0] RST_CALCTL = 8'h40;
  localparam int OVR_EN_BIT = 7;
  localparam int SECOND_SEL_LSB = 4;
  localparam int FIRST_SEL_LSB = 2;
  localparam int SE_REF_BIT = 1;
  localparam int SYN_EN_BIT = 0;
  localparam int CAL_EN_BIT = 0;
  localparam int SETTLE_LSB = 4;
  // Settling base time per settle step in ns; cycles derived from 5 ns clock
  localparam int SETTLE_BASE_NS = 640;
  localparam int CLK_PERIOD_NS = 5;
  localparam int SETTLE_BASE_CYC = (SETTLE_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [1:0] DIV_OFF = 2'h0;
  localparam logic [1:0] DIV_1 = 2'h1;
  localparam logic [1:0] DIV_2 = 2'h2;
  localparam logic [1:0] DIV_4 = 2'h3;

  typedef struct packed {
    logic synth_enable;
    logic se_ref_select;
    logic [1:0] first_sel;
    logic [1:0] second_sel;
  } spc_cfg_s;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } spc_req_s;

  typedef enum logic [3:0] {
    CAL_IDLE = 4'b0001,
    CAL_STEP = 4'b0010,
    CAL_WAIT = 4'b0100,
    CAL_DONE = 4'b1000
  } spc_cal_e;
endpackage

/* File: rtl/spc_refdiv.sv */
// Purpose: One divided-reference output with off, /1, /2, /4 modes
// Assumes: i_ref_tick is a one-cycle enable marking a reference edge
// Notes: Output toggles on ticks; /1 toggles each tick
`timescale 1ns/1ps
`default_nettype none
module spc_refdiv
  import spc_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // Control
  input wire logic i_ref_tick,
  input wire logic [1:0] i_sel,
  // Output
  output logic o_clk_out,
  output logic o_running
);
  import spc_pkg::*;

  logic [1:0] cnt_r;
  logic [1:0] cnt_nxt;
  logic out_r;
  logic out_nxt;
  logic [1:0] limit;

  always_comb
  begin
    limit = 2'h0;
    if (i_sel == DIV_2)
      limit = 2'h1;
    else if (i_sel == DIV_4)
      limit = 2'h3;
    cnt_nxt = cnt_r;
    out_nxt = out_r;
    if (i_sel == DIV_OFF)
    begin
      cnt_nxt = 2'h0;
      out_nxt = 1'b0;
    end
    else if (i_ref_tick)
    begin
      if (cnt_r >= limit)
      begin
        cnt_nxt = 2'h0;
        out_nxt = ~out_r;
      end
      else
        cnt_nxt = cnt_r + 2'h1;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      cnt_r <= 2'h0;
      out_r <= 1'b0;
    end
    else
    begin
      cnt_r <= cnt_nxt;
      out_r <= out_nxt;
    end
  end

  assign o_clk_out = out_r;
  assign o_running = (i_sel != DIV_OFF);
endmodule // spc_refdiv
`default_nettype wire

/* File: rtl/spc_ctrl.sv */
// Purpose: Synthesizer pin override, divided reference outputs, trim and calibration
// Assumes: Byte register port on the same clock; compare input from oscillator detector
// Notes: Calibration is a binary search on the trim, one step per settle interval
`timescale 1ns/1ps
`default_nettype none
module spc_ctrl
  import spc_pkg::*;
#(
  parameter int SETTLE_UNIT_CYC = SETTLE_BASE_CYC
)
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // Register port
  input wire spc_pkg::spc_req_s i_req,
  output logic [7:0] o_rdata,
  // Strap pins
  input wire logic i_synth_en_pin,
  input wire logic i_se_refclk_pin,
  input wire logic i_clock_config_pin0,
  input wire logic i_clock_config_pin1,
  // Analog interface
  input wire logic i_ref_tick,
  input wire logic i_osc_too_slow,
  output spc_pkg::spc_cfg_s o_cfg,
  output logic [6:0] o_oscillator_freq_trim,
  output logic o_synth_reset,
  // Divided reference outputs
  output logic o_refout_first,
  output logic o_refout_second
);
  import spc_pkg::*;

  logic [7:0] ovr_r, ovr_nxt;
  logic [6:0] trim_r, trim_nxt;
  logic rst_bit_r, rst_bit_nxt;
  logic [7:0] calctl_r, calctl_nxt;
  logic done_r, done_nxt;
  spc_cal_e state_r, state_nxt;
  logic [2:0] bit_r, bit_nxt;
  logic [12:0] wait_r, wait_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [2:0] pin_sync_r [4];
  logic [2:0] pin_sync_nxt [4];
  logic [3:0] pin_stable_r, pin_stable_nxt;
  spc_cfg_s cfg;
  logic first_running;
  logic [1:0] second_sel_eff;
  logic [6:0] step_mask;

  // Strap pins: three-stage sync, level taken once stages two and three agree
  always_comb
  begin
    pin_sync_nxt[0] = {pin_sync_r[0][1:0], i_synth_en_pin};
    pin_sync_nxt[1] = {pin_sync_r[1][1:0], i_se_refclk_pin};
    pin_sync_nxt[2] = {pin_sync_r[2][1:0], i_clock_config_pin0};
    pin_sync_nxt[3] = {pin_sync_r[3][1:0], i_clock_config_pin1};
    pin_stable_nxt = pin_stable_r;
    for (int i = 0; i < 4; i++)
    begin
      if (pin_sync_r[i][1] == pin_sync_r[i][2])
        pin_stable_nxt[i] = pin_sync_r[i][2];
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      for (int i = 0; i < 4; i++)
        pin_sync_r[i] <= 3'h0;
      pin_stable_r <= 4'h0;
    end
    else
    begin
      pin_sync_r <= pin_sync_nxt;
      pin_stable_r <= pin_stable_nxt;
    end
  end

  // Configuration select
  always_comb
  begin
    if (ovr_r[OVR_EN_BIT])
    begin
      cfg.synth_enable = ovr_r[SYN_EN_BIT];
      cfg.se_ref_select = ovr_r[SE_REF_BIT];
      cfg.first_sel = ovr_r[FIRST_SEL_LSB +: 2];
      cfg.second_sel = ovr_r[SECOND_SEL_LSB +: 2];
    end
    else
    begin
      cfg.synth_enable = pin_stable_r[0];
      cfg.se_ref_select = pin_stable_r[1];
      // Straps choose: 00 off, 01 first /1, 10 first /2, 11 both /1
      unique case (pin_stable_r[3:2])
        2'h0: begin cfg.first_sel = DIV_OFF; cfg.second_sel = DIV_OFF; end
        2'h1: begin cfg.first_sel = DIV_1; cfg.second_sel = DIV_OFF; end
        2'h2: begin cfg.first_sel = DIV_2; cfg.second_sel = DIV_OFF; end
        2'h3: begin cfg.first_sel = DIV_1; cfg.second_sel = DIV_1; end
      endcase
    end
  end

  // Second output gated so it never runs alone
  assign second_sel_eff = first_running ? cfg.second_sel : DIV_OFF;

  spc_refdiv u_first (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_ref_tick(i_ref_tick),
    .i_sel(cfg.first_sel),
    .o_clk_out(o_refout_first),
    .o_running(first_running)
  );

  spc_refdiv u_second (
    .i_clock(i_clock),
    .i_rst_b(i_rst_b),
    .i_ref_tick(i_ref_tick),
    .i_sel(second_sel_eff),
    .o_clk_out(o_refout_second),
    .o_running()
  );

  assign step_mask = 7'(7'h01 << bit_r);

  // Registers and calibration engine
  always_comb
  begin
    ovr_nxt = ovr_r;
    trim_nxt = trim_r;
    rst_bit_nxt = rst_bit_r;
    calctl_nxt = calctl_r;
    done_nxt = done_r;
    state_nxt = state_r;
    bit_nxt = bit_r;
    wait_nxt = wait_r;
    rdata_nxt = rdata_r;
    if (i_req.wr)
    begin
      unique case (i_req.addr)
        ADDR_OVERRIDE: ovr_nxt = i_req.wdata;
        ADDR_TRIM: trim_nxt = i_req.wdata[6:0];
        ADDR_RESET: rst_bit_nxt = i_req.wdata[0];
        ADDR_CALCTL: calctl_nxt = i_req.wdata;
        default: ;
      endcase
    end
    if (i_req.rd)
    begin
      unique case (i_req.addr)
        ADDR_OVERRIDE: rdata_nxt = ovr_r;
        ADDR_TRIM: rdata_nxt = {1'b0, trim_r};
        ADDR_RESET: rdata_nxt = {7'h00, rst_bit_r};
        ADDR_CALCTL: rdata_nxt = calctl_r;
        ADDR_CALSTAT: rdata_nxt = {7'h00, done_r};
        default: rdata_nxt = 8'h00;
      endcase
    end
    unique case (state_r)
      CAL_IDLE:
      begin
        if (!rst_bit_r)
        begin
          if (calctl_r[CAL_EN_BIT])
          begin
            bit_nxt = 3'h6;
            trim_nxt = 7'h40;
            wait_nxt = 13'(SETTLE_UNIT_CYC * (int'(calctl_r[SETTLE_LSB +: 3]) + 1));
            state_nxt = CAL_WAIT;
          end
          else
          begin
            done_nxt = 1'b1;
            state_nxt = CAL_DONE;
          end
        end
      end
      CAL_WAIT:
      begin
        if (wait_r != 13'h0000)
          wait_nxt = wait_r - 13'h0001;
        else
          state_nxt = CAL_STEP;
      end
      CAL_STEP:
      begin
        // Keep the bit if oscillator still runs slow, else drop it
        if (!i_osc_too_slow)
          trim_nxt = trim_r & ~step_mask;
        if (bit_r == 3'h0)
        begin
          done_nxt = 1'b1;
          state_nxt = CAL_DONE;
        end
        else
        begin
          bit_nxt = bit_r - 3'h1;
          trim_nxt = (i_osc_too_slow ? trim_r : (trim_r & ~step_mask)) | (step_mask >> 1);
          wait_nxt = 13'(SETTLE_UNIT_CYC * (int'(calctl_r[SETTLE_LSB +: 3]) + 1));
          state_nxt = CAL_WAIT;
        end
      end
      CAL_DONE: ;
    endcase
    if (rst_bit_r)
    begin
      done_nxt = 1'b0;
      state_nxt = CAL_IDLE;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      ovr_r <= RST_OVERRIDE;
      trim_r <= RST_TRIM;
      rst_bit_r <= RST_RESET[0];
      calctl_r <= RST_CALCTL;
      done_r <= 1'b0;
      state_r <= CAL_IDLE;
      bit_r <= 3'h0;
      wait_r <= 13'h0000;
      rdata_r <= 8'h00;
    end
    else
    begin
      ovr_r <= ovr_nxt;
      trim_r <= trim_nxt;
      rst_bit_r <= rst_bit_nxt;
      calctl_r <= calctl_nxt;
      done_r <= done_nxt;
      state_r <= state_nxt;
      bit_r <= bit_nxt;
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign o_rdata = rdata_r;
  assign o_cfg = cfg;
  assign o_oscillator_freq_trim = trim_r;
  assign o_synth_reset = rst_bit_r;
endmodule // spc_ctrl
`default_nettype wire

/* File: bench/spc_ctrl_asserts.sv */
// Purpose: Port-level checks for the synthesizer override and calibration control
// Assumes: Sees only spc_ctrl ports; override mode shown through o_cfg
// Notes: Bound to every spc_ctrl instance
`timescale 1ns/1ps
`default_nettype none
module spc_ctrl_asserts
  import spc_pkg::*;
(
  // Clock and reset
  input wire logic i_clock,
  input wire logic i_rst_b,
  // Watched ports
  input wire spc_pkg::spc_req_s i_req,
  input wire logic [7:0] o_rdata,
  input wire logic i_ref_tick,
  input wire spc_pkg::spc_cfg_s o_cfg,
  input wire logic [6:0] o_oscillator_freq_trim,
  input wire logic o_synth_reset,
  input wire logic o_refout_first,
  input wire logic o_refout_second
);
  import spc_pkg::*;

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (!i_rst_b);
  wire logic ovr_wr = i_req.wr && i_req.addr == ADDR_OVERRIDE && i_req.wdata[7];
  a_ovr_fields: assert property (
    ovr_wr |=> o_cfg.synth_enable == $past(i_req.wdata[0])
      && o_cfg.se_ref_select == $past(i_req.wdata[1]))
    else $error("override enable fields not applied");
  a_first_sel: assert property (
    ovr_wr |=> o_cfg.first_sel == $past(i_req.wdata[3:2]))
    else $error("first divide select not applied");
  a_second_sel: assert property (
    ovr_wr && i_req.wdata[3:2] != DIV_OFF |=> o_cfg.second_sel == $past(i_req.wdata[5:4]))
    else $error("second divide select not applied");
  a_off_static: assert property (
    (o_cfg.first_sel == DIV_OFF) [*2] |-> !o_refout_first && !o_refout_second)
    else $error("output active while first output is off");
  a_tick_cause: assert property (
    $changed(o_refout_first) && $past(o_cfg.first_sel) != DIV_OFF |-> $past(i_ref_tick))
    else $error("first output changed without a tick");
  a_div1_toggle: assert property (
    $past(o_cfg.first_sel) == DIV_1 && $past(o_cfg.first_sel, 2) == DIV_1
      && $past(i_ref_tick) |-> $changed(o_refout_first))
    else $error("divide-by-one output missed a tick");
  a_trim_read: assert property (
    i_req.rd && i_req.addr == ADDR_TRIM |=> o_rdata == {1'b0, $past(o_oscillator_freq_trim)})
    else $error("trim read data wrong");
  a_rst_write: assert property (
    i_req.wr && i_req.addr == ADDR_RESET |=> o_synth_reset == $past(i_req.wdata[0]))
    else $error("synth reset bit not written");
  a_rst_read: assert property (
    i_req.rd && i_req.addr == ADDR_RESET |=> o_rdata == {7'h00, $past(o_synth_reset)})
    else $error("synth reset read data wrong");
  // Engine must sit idle while the synth reset is held
  a_trim_frozen: assert property (
    o_synth_reset && $past(o_synth_reset) && !i_req.wr |=> $stable(o_oscillator_freq_trim))
    else $error("trim moved while synth reset held");
endmodule // spc_ctrl_asserts

bind spc_ctrl spc_ctrl_asserts u_spc_chk (
  .i_clock(i_clock), .i_rst_b(i_rst_b), .i_req(i_req), .o_rdata(o_rdata),
  .i_ref_tick(i_ref_tick), .o_cfg(o_cfg), .o_oscillator_freq_trim(o_oscillator_freq_trim),
  .o_synth_reset(o_synth_reset), .o_refout_first(o_refout_first),
  .o_refout_second(o_refout_second)
);
`default_nettype wire

/* File: bench/spc_ctrl_tb_top.sv */
// Purpose: Self-checking bench for the synthesizer override and calibration control
// Assumes: Short settle unit keeps calibration runs brief
// Notes: Oscillator modelled as a threshold on the trim
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin bad_count++; \
  $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
module spc_ctrl_tb_top;
  import spc_pkg::*;
  logic i_clock = 0, i_rst_b = 0, i_ref_tick = 0, i_osc_too_slow = 0;
  logic [3:0] pins = 4'h0;
  spc_req_s i_req = '0;
  spc_cfg_s o_cfg;
  logic [7:0] o_rdata, d;
  logic [6:0] trim, target = 7'h00;
  logic o_synth_reset, ro1, ro2;
  logic [7:0] ra [6] = '{ADDR_OVERRIDE, ADDR_TRIM, ADDR_RESET, ADDR_CALCTL, ADDR_CALSTAT, 8'h00};
  logic [7:0] rv [6] = '{8'h00, 8'h00, 8'h00, 8'h40, 8'h01, 8'h00};
  int bad_count = 0, n_checks = 0, t1, t2;
  always #2.5 i_clock = ~i_clock;
  spc_ctrl #(.SETTLE_UNIT_CYC(2)) DUT (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_req(i_req), .o_rdata(o_rdata),
    .i_synth_en_pin(pins[0]), .i_se_refclk_pin(pins[1]),
    .i_clock_config_pin0(pins[2]), .i_clock_config_pin1(pins[3]),
    .i_ref_tick(i_ref_tick), .i_osc_too_slow(i_osc_too_slow), .o_cfg(o_cfg),
    .o_oscillator_freq_trim(trim), .o_synth_reset(o_synth_reset),
    .o_refout_first(ro1), .o_refout_second(ro2)
  );
  // Oscillator runs slow while trim is below the target
  always @(negedge i_clock) i_osc_too_slow <= trim < target;
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge i_clock) i_req = '{1'b1, 1'b0, a, v};
    @(negedge i_clock) i_req = '0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(negedge i_clock) i_req = '{1'b0, 1'b1, a, 8'h00};
    @(negedge i_clock) i_req = '0;
    d = o_rdata;
  endtask
  function automatic spc_cfg_s pin_cfg(logic [3:0] p);
    logic [1:0] f;
    f = p[3:2] == 2'h3 ? DIV_1 : p[3:2];
    return '{p[0], p[1], f, p[3:2] == 2'h3 ? DIV_1 : DIV_OFF};
  endfunction
  function automatic int tg_exp(logic [1:0] s);
    return s == DIV_OFF ? 0 : 16 >> (s - 2'h1);
  endfunction
  // Sixteen tick pulses; extra edge first so a select change has landed
  task automatic run_ticks(output int c1, output int c2);
    logic a, b;
    c1 = 0;
    c2 = 0;
    @(negedge i_clock);
    a = ro1;
    b = ro2;
    repeat (32)
    begin
      @(negedge i_clock) i_ref_tick = ~i_ref_tick;
      c1 += int'(ro1 != a);
      c2 += int'(ro2 != b);
      a = ro1;
      b = ro2;
    end
  endtask
  task automatic cal(input logic [7:0] ctl, input logic [6:0] tg, output int cyc);
    target = tg;
    wr(ADDR_RESET, 8'h01);
    rd(ADDR_CALSTAT);
    `CHK(d, 8'h00)
    wr(ADDR_CALCTL, ctl);
    wr(ADDR_RESET, 8'h00);
    cyc = 0;
    while (d[0] !== 1'b1 && cyc < 400)
    begin
      rd(ADDR_CALSTAT);
      cyc++;
    end
    `CHK(d, 8'h01)
    // Trim is touched only once done reads back set
    rd(ADDR_TRIM);
    `CHK(d, {1'b0, tg == 7'h00 ? 7'h00 : tg - 7'h01})
  endtask
  task automatic print_verdict;
    $display("checks=%0d mismatches=%0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Whole run needs about 1000 cycles; allow ample margin
  initial
  begin
    #50us;
    bad_count++;
    print_verdict();
  end
  initial
  begin
    void'($urandom(10));
    repeat (4) @(negedge i_clock);
    i_rst_b = 1'b1;
    foreach (ra[i])
    begin
      rd(ra[i]);
      `CHK(d, rv[i])
    end
    $display("test reset_values done");
    wr(ADDR_OVERRIDE, {2'b00, 6'($urandom)});
    for (int k = 0; k < 16; k++)
    begin
      pins = k[3:0];
      repeat (6) @(negedge i_clock);
      `CHK(o_cfg, pin_cfg(pins))
    end
    run_ticks(t1, t2);
    `CHK(t1 + t2, 32)
    $display("test pin_mode done");
    for (int k = 0; k < 16; k++)
    begin
      // Random enable and reference-type bits; reserved bit 6 stays zero
      d = {2'b10, k[3:0], 2'($urandom)};
      wr(ADDR_OVERRIDE, d);
      `CHK(o_cfg, {d[0], d[1], d[3:2], d[5:4]})
      run_ticks(t1, t2);
      `CHK(t1, tg_exp(k[1:0]))
      `CHK(t2, k[1:0] == 2'h0 ? 0 : tg_exp(k[3:2]))
    end
    $display("test override_dividers done");
    cal(8'h41, 7'($urandom), t1);
    cal(8'h01, 7'h00, t1);
    cal(8'h71, 7'h7f, t2);
    `CHK(t2 > t1, 1'b1)
    t1 = $urandom;
    wr(ADDR_TRIM, {1'b0, t1[6:0]});
    rd(ADDR_TRIM);
    `CHK(d, {1'b0, t1[6:0]})
    $display("test calibration done");
    print_verdict();
  end
endmodule // spc_ctrl_tb_top
`default_nettype wire
